// [rtl/adcsq_ctrl.sv]
// sequencer, timing and APB register file of the 16-channel 10-bit converter control
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "adcsq_map.svh"
module adcsq_ctrl #(
  parameter int NCH = 16,
  parameter int RW  = 10
) (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_b_i,
  // apb slave
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [11:0]     paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  // converter core
  output logic      [3:0]      mux_sel_o,
  output logic                 sample_o,
  output logic                 conv_step_o,
  input  wire logic [RW-1:0]   core_data_i,
  input  wire logic [NCH-1:0]  digin_i,
  // events
  output logic                 event_req_o,
  output logic                 irq_o
);
  import adcsq_pkg::*;
  if (NCH != 16 || RW != 10) $error("adcsq_ctrl: only 16 channels of 10 bits are served");
  adcsq_state_t state_q;
  logic [3:0]   chan_q, inj_chan_q;
  adcsq_mode_t  mode_q;
  logic         wait_q, prot_q, busy_q, inj_pend_q, inj_act_q;
  logic [1:0]   ctc_q, stc_q;
  logic [15:0]  scan_mask_q;
  logic [7:0]   tick_q;
  logic [3:0]   tcc_cnt_q;
  logic [3:0]   step_q;
  logic [RW-1:0] res_val_q, inj_val_q;
  logic [3:0]   res_ch_q, inj_ch_q;
  logic         res_full_q;
  logic [2:0]   stat_q, mask_q;
  logic         evt_q;
  logic [13:0]  hold_data;
  logic wr_acc, rd_acc;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  // conversion clock period in mclk cycles
  function automatic logic [7:0] tcc_cycles(input logic [1:0] code);
    unique case (code)
      2'b00:   tcc_cycles = 8'(`ADCSQ_CTC_00 * `ADCSQ_TCL_CYCLES);
      2'b10:   tcc_cycles = 8'(`ADCSQ_CTC_10 * `ADCSQ_TCL_CYCLES);
      2'b11:   tcc_cycles = 8'(`ADCSQ_CTC_11 * `ADCSQ_TCL_CYCLES);
      default: tcc_cycles = 8'(`ADCSQ_CTC_00 * `ADCSQ_TCL_CYCLES);
    endcase
  endfunction : tcc_cycles
  // next selected scan channel at or after a start index, wrapping
  function automatic logic [4:0] next_scan(input logic [15:0] m, input logic [3:0] from);
    logic [4:0] r;
    logic [3:0] idx;
    r = 5'h10;
    for (int k = 15; k >= 0; k--) begin
      idx = 4'(from + 4'(k));
      if (m[idx]) r = {1'b0, idx};
    end
    next_scan = r;
  endfunction : next_scan
  logic rd_result, cont_mode, scan_mode, start_wr;
  assign rd_result = rd_acc && paddr_i == `ADCSQ_OFF_RESULT;
  assign cont_mode = mode_q == ADCSQ_SINGLE_CONT || mode_q == ADCSQ_SCAN_CONT;
  assign scan_mode = mode_q == ADCSQ_SCAN_ONCE || mode_q == ADCSQ_SCAN_CONT;
  assign start_wr  = wr_acc && paddr_i == `ADCSQ_OFF_CTRL && pwdata_i[`ADCSQ_CTRL_START];
  logic tcc_tick;
  assign tcc_tick = tick_q == 8'h00;
  // base timing: one pulse per conversion clock period, restarted before every sample phase
  // so that each sample time is whole periods long; a start uses the clock code written with it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_q <= 8'h00;
    end else if (state_q == ADCSQ_IDLE) begin
      tick_q <= 8'(tcc_cycles(start_wr ? pwdata_i[`ADCSQ_CTRL_CTC_LSB +: 2] : ctc_q) - 8'h01);
    end else if (state_q == ADCSQ_STORE || state_q == ADCSQ_HOLD || tcc_tick) begin
      tick_q <= 8'(tcc_cycles(ctc_q) - 8'h01);
    end else begin
      tick_q <= 8'(tick_q - 8'h01);
    end
  end
  logic [4:0] scan_nx;
  assign scan_nx = next_scan(scan_mask_q, 4'(chan_q + 4'h1));
  logic store_now, res_blocked;
  assign store_now   = state_q == ADCSQ_STORE;
  assign res_blocked = res_full_q && !rd_result && (prot_q || (wait_q && cont_mode));

  // sequencer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q   <= ADCSQ_IDLE;
      busy_q    <= 1'b0;
      inj_act_q <= 1'b0;
      tcc_cnt_q <= 4'h0;
      step_q    <= 4'h0;
      mux_sel_o <= 4'h0;
      sample_o  <= 1'b0;
      conv_step_o <= 1'b0;
    end else begin
      conv_step_o <= 1'b0;
      unique case (state_q)
        ADCSQ_IDLE: begin
          if (start_wr) begin
            state_q   <= ADCSQ_SAMPLE;
            busy_q    <= 1'b1;
            mux_sel_o <= pwdata_i[`ADCSQ_CTRL_CH_LSB +: 4];
            sample_o  <= 1'b1;
            tcc_cnt_q <= 4'h0;
          end
        end
        ADCSQ_SAMPLE: begin
          if (tcc_tick) begin
            if (tcc_cnt_q == 4'((4'h1 << stc_q) - 4'h1)) begin
              state_q  <= ADCSQ_CONVERT;
              sample_o <= 1'b0;
              step_q   <= 4'h0;
            end else begin
              tcc_cnt_q <= 4'(tcc_cnt_q + 4'h1);
            end
          end
        end
        ADCSQ_CONVERT: begin
          if (tcc_tick) begin
            conv_step_o <= 1'b1;
            if (step_q == 4'(`ADCSQ_CONV_STEPS - 1)) state_q <= ADCSQ_STORE;
            else step_q <= 4'(step_q + 4'h1);
          end
        end
        ADCSQ_STORE: begin
          if (inj_act_q) begin
            inj_act_q <= 1'b0;
            mux_sel_o <= chan_q;
            state_q   <= ADCSQ_SAMPLE;
            sample_o  <= 1'b1;
            tcc_cnt_q <= 4'h0;
          end else begin
            state_q <= ADCSQ_HOLD;
          end
        end
        ADCSQ_HOLD: begin
          if (!res_blocked) begin
            tcc_cnt_q <= 4'h0;
            if (inj_pend_q && cont_mode) begin
              inj_act_q <= 1'b1;
              mux_sel_o <= inj_chan_q;
              state_q   <= ADCSQ_SAMPLE;
              sample_o  <= 1'b1;
            end else if (mode_q == ADCSQ_SINGLE_ONCE) begin
              state_q <= ADCSQ_IDLE;
              busy_q  <= 1'b0;
            end else if (mode_q == ADCSQ_SINGLE_CONT) begin
              state_q  <= ADCSQ_SAMPLE;
              sample_o <= 1'b1;
            end else if (scan_nx[4] || (mode_q == ADCSQ_SCAN_ONCE && scan_nx[3:0] <= chan_q)) begin
              state_q <= ADCSQ_IDLE;
              busy_q  <= 1'b0;
            end else begin
              mux_sel_o <= scan_nx[3:0];
              state_q   <= ADCSQ_SAMPLE;
              sample_o  <= 1'b1;
            end
          end
        end
        default: state_q <= ADCSQ_IDLE;
      endcase
    end
  end
  // channel currently serviced by the normal sequence
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_q <= 4'h0;
    end else if (state_q == ADCSQ_IDLE && start_wr) begin
      chan_q <= pwdata_i[`ADCSQ_CTRL_CH_LSB +: 4];
    end else if (state_q == ADCSQ_HOLD && !res_blocked && !(inj_pend_q && cont_mode) &&
                 scan_mode && !scan_nx[4]) begin
      chan_q <= scan_nx[3:0];
    end
  end
  // a finished normal result goes into the hold buffer
  logic hold_wr;
  assign hold_wr = store_now && !inj_act_q;
  adcsq_hold_buf #(
    .W (14)
  ) u_hold (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .wr_i    (hold_wr),
    .wdata_i ({chan_q, core_data_i}),
    .rdata_o (hold_data)
  );
  logic hold_pend_q, hold_load;
  assign hold_load = hold_pend_q && (!res_full_q || rd_result || !(prot_q || (wait_q && cont_mode)));
  // result register, overrun and wait-for-read
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_pend_q <= 1'b0;
      res_val_q   <= '0;
      res_ch_q    <= 4'h0;
      res_full_q  <= 1'b0;
      evt_q       <= 1'b0;
    end else begin
      evt_q <= 1'b0;
      if (hold_wr) hold_pend_q <= 1'b1;
      else if (hold_load) hold_pend_q <= 1'b0;
      if (hold_load && !hold_wr) begin
        res_val_q  <= hold_data[RW-1:0];
        res_ch_q   <= hold_data[13:10];
        res_full_q <= 1'b1;
        evt_q      <= 1'b1;
      end else if (rd_result) begin
        res_full_q <= 1'b0;
      end
    end
  end

  // injected conversion result
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inj_val_q  <= '0;
      inj_ch_q   <= 4'h0;
      inj_pend_q <= 1'b0;
    end else begin
      if (store_now && inj_act_q) begin
        inj_val_q <= core_data_i;
        inj_ch_q  <= inj_chan_q;
      end
      if (wr_acc && paddr_i == `ADCSQ_OFF_CTRL && pwdata_i[`ADCSQ_CTRL_INJ_REQ] && busy_q && cont_mode)
        inj_pend_q <= 1'b1;
      else if (state_q == ADCSQ_HOLD && !res_blocked && cont_mode)
        inj_pend_q <= 1'b0;
    end
  end
  logic ovr_evt, inj_evt;
  assign ovr_evt = hold_load && !hold_wr && res_full_q && !rd_result && !prot_q;
  assign inj_evt = store_now && inj_act_q;
  // control fields and scan mask held while busy so an injection changes nothing; injection channel and irq mask always writable
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q      <= ADCSQ_SINGLE_ONCE;
      wait_q      <= 1'b0;
      prot_q      <= 1'b0;
      ctc_q       <= 2'b00;
      stc_q       <= 2'b00;
      inj_chan_q  <= 4'h0;
      scan_mask_q <= 16'h0000;
      mask_q      <= 3'h0;
    end else if (wr_acc) begin
      if (paddr_i == `ADCSQ_OFF_CTRL && !busy_q) begin
        mode_q <= adcsq_mode_t'(pwdata_i[`ADCSQ_CTRL_MODE_LSB +: 2]);
        wait_q <= pwdata_i[`ADCSQ_CTRL_WAIT];
        prot_q <= pwdata_i[`ADCSQ_CTRL_PROT];
        ctc_q  <= pwdata_i[`ADCSQ_CTRL_CTC_LSB +: 2];
        stc_q  <= pwdata_i[`ADCSQ_CTRL_STC_LSB +: 2];
      end
      if (paddr_i == `ADCSQ_OFF_INJ) inj_chan_q <= pwdata_i[3:0];
      if (paddr_i == `ADCSQ_OFF_SCANMASK && !busy_q) scan_mask_q <= pwdata_i[15:0];
      if (paddr_i == `ADCSQ_OFF_IRQ_MASK) mask_q <= pwdata_i[2:0];
    end
  end

  // sticky status, set wins over write-one-to-clear
  logic [2:0] set_v;
  assign set_v = {inj_evt, ovr_evt, evt_q};
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~((wr_acc && paddr_i == `ADCSQ_OFF_IRQ_STAT) ? pwdata_i[2:0] : 3'h0)) | set_v;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o       <= 1'b0;
      event_req_o <= 1'b0;
    end else begin
      irq_o       <= |(stat_q & mask_q);
      event_req_o <= evt_q;
    end
  end
  // apb read data and answer; access phase finishes in one cycle
  logic [31:0] rd_v;
  logic        map_ok;
  always_comb begin
    rd_v   = 32'h0000_0000;
    map_ok = 1'b1;
    unique case (paddr_i)
      `ADCSQ_OFF_CTRL:     rd_v = {16'h0000, ctc_q, stc_q, inj_pend_q, prot_q, wait_q, busy_q, 1'b0,
                                   1'b0, mode_q, chan_q};
      `ADCSQ_OFF_RESULT:   rd_v = {16'h0000, res_ch_q, 2'b00, res_val_q};
      `ADCSQ_OFF_INJ:      rd_v = {16'h0000, inj_ch_q, 2'b00, inj_val_q};
      `ADCSQ_OFF_SCANMASK: rd_v = {16'h0000, scan_mask_q};
      `ADCSQ_OFF_IRQ_STAT: rd_v = {29'h0, stat_q};
      `ADCSQ_OFF_IRQ_MASK: rd_v = {29'h0, mask_q};
      `ADCSQ_OFF_DIGIN:    rd_v = {16'h0000, digin_i & ~scan_mask_q};
      default:             map_ok = 1'b0;
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !map_ok;
      prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rd_v : 32'h0000_0000;
    end
  end
endmodule : adcsq_ctrl

// [rtl/adcsq_map.svh]
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH
`define ADCSQ_OFF_CTRL      12'h000
`define ADCSQ_OFF_RESULT    12'h004
`define ADCSQ_OFF_INJ       12'h008
`define ADCSQ_OFF_SCANMASK  12'h00c
`define ADCSQ_OFF_IRQ_STAT  12'h010
`define ADCSQ_OFF_IRQ_MASK  12'h014
`define ADCSQ_OFF_DIGIN     12'h018
`define ADCSQ_CTRL_CH_LSB   0
`define ADCSQ_CTRL_MODE_LSB 4
`define ADCSQ_CTRL_START    7
`define ADCSQ_CTRL_BUSY     8
`define ADCSQ_CTRL_WAIT     9
`define ADCSQ_CTRL_PROT     10
`define ADCSQ_CTRL_INJ_REQ  11
`define ADCSQ_CTRL_STC_LSB  12
`define ADCSQ_CTRL_CTC_LSB  14
`define ADCSQ_IRQ_DONE      0
`define ADCSQ_IRQ_OVR       1
`define ADCSQ_IRQ_INJ       2
`define ADCSQ_CTRL_RESET    32'h0000_0000
`define ADCSQ_TCL_CYCLES    2
`define ADCSQ_CTC_00        24
`define ADCSQ_CTC_10        96
`define ADCSQ_CTC_11        48
`define ADCSQ_CONV_STEPS    10
`endif

// [rtl/adcsq_pkg.sv]
// types of the converter control
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_SINGLE_ONCE,
    ADCSQ_SINGLE_CONT,
    ADCSQ_SCAN_ONCE,
    ADCSQ_SCAN_CONT
  } adcsq_mode_t;
  typedef enum logic [2:0] {
    ADCSQ_IDLE,
    ADCSQ_SAMPLE,
    ADCSQ_CONVERT,
    ADCSQ_STORE,
    ADCSQ_HOLD
  } adcsq_state_t;
endpackage : adcsq_pkg

// [rtl/adcsq_hold_buf.sv]
// one-entry hold buffer for a finished result waiting for the result register to be read
`timescale 1ns/1ps
module adcsq_hold_buf #(
  parameter int W = 14
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  // write and read
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] rdata_o
);
  if (W < 1) $error("adcsq_hold_buf: width must be positive");
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (wr_i) begin
      rdata_o <= wdata_i;
    end
  end
endmodule : adcsq_hold_buf

// [bench/adcsq_core_model.sv]
// behavioural analog multiplexer and converter core seen by the sequencer
`timescale 1ns/1ps
module adcsq_core_model #(
  parameter logic [15:0] DIG = 16'ha5c3
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // from the sequencer
  input  wire logic [3:0]  mux_sel_i,
  input  wire logic        sample_i,
  input  wire logic        conv_step_i,
  // to the sequencer
  output logic      [9:0]  data_o,
  output logic      [15:0] digin_o
);
  assign digin_o = DIG;
  // the result lines toggle while sampling so a stale value never looks valid
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) data_o <= 10'h155;
    else if (conv_step_i) data_o <= {mux_sel_i, 6'h2b};
    else if (sample_i) data_o <= ~data_o;
  end
endmodule : adcsq_core_model

// [bench/adcsq_ctrl_assertions.sv]
// port-level checker of the converter control
`timescale 1ns/1ps
module adcsq_ctrl_assertions (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic [3:0]  mux_sel_o,
  input wire logic        sample_o,
  input wire logic        conv_step_o,
  input wire logic        event_req_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  int samp_n;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) samp_n <= 0;
    else if (sample_o) samp_n <= samp_n + 1;
    else samp_n <= 0;
  end
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_answer; pready_o ##1 !pready_o; endsequence
  chk_apb_answer: assert property (s_setup |=> s_answer) else $error("apb answer late");
  chk_err_qual: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside ready");
  chk_event_pulse: assert property (event_req_o |=> !event_req_o) else $error("event not a pulse");
  chk_step_gap: assert property (conv_step_o |=> !conv_step_o [*8]) else $error("steps too close");
  chk_step_apart: assert property (conv_step_o |-> !sample_o) else $error("step while sampling");
  chk_sample_len: assert property ($fell(sample_o) |-> samp_n >= 48 && samp_n % 48 == 0)
    else $error("sample length wrong");
  chk_mux_hold: assert property (sample_o && $past(sample_o) |-> $stable(mux_sel_o))
    else $error("channel moved while sampling");
endmodule : adcsq_ctrl_assertions
bind adcsq_ctrl adcsq_ctrl_assertions u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
  .mux_sel_o(mux_sel_o), .sample_o(sample_o), .conv_step_o(conv_step_o), .event_req_o(event_req_o));

// [bench/tb.sv]
// self-checking testbench of the converter control
`timescale 1ns/1ps
`include "adcsq_map.svh"
module tb;
  import adcsq_pkg::*;
  localparam logic [15:0] DIG = 16'ha5c3;
  logic        mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, sample, step, evt, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  mux;
  logic [9:0]  core;
  logic [15:0] digin;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n, m;
  adcsq_ctrl dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .mux_sel_o(mux), .sample_o(sample), .conv_step_o(step), .core_data_i(core), .digin_i(digin),
    .event_req_o(evt), .irq_o(irq));
  adcsq_core_model #(.DIG(DIG)) u_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mux_sel_i(mux),
    .sample_i(sample), .conv_step_i(step), .data_o(core), .digin_o(digin));
  initial begin
    mclk_i = 1'h0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      final_report;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'h1;
    do @(posedge mclk_i); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task wait_evt;
    while (evt !== 1'h1) @(posedge mclk_i);
    @(posedge mclk_i);
  endtask : wait_evt
  task do_reset;
    rst_b_i <= 1'h0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'h1;
  endtask : do_reset
  function automatic logic [31:0] res(input logic [3:0] c);
    return {16'h0, c, 2'h0, c, 6'h2b};
  endfunction : res
  task t_regs;
    xfer(1'h0, `ADCSQ_OFF_CTRL, 32'h0);
    chk(r, `ADCSQ_CTRL_RESET);
    xfer(1'h0, 12'h01c, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("registers done");
  endtask : t_regs
  task t_clocks;
    logic [1:0] ctc [4];
    logic [1:0] stc [4];
    int         per [4];
    ctc = '{2'h0, 2'h2, 2'h3, 2'h0};
    stc = '{2'h0, 2'h3, 2'h1, 2'h2};
    per = '{`ADCSQ_TCL_CYCLES * `ADCSQ_CTC_00, `ADCSQ_TCL_CYCLES * `ADCSQ_CTC_10,
            `ADCSQ_TCL_CYCLES * `ADCSQ_CTC_11, `ADCSQ_TCL_CYCLES * `ADCSQ_CTC_00};
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, `ADCSQ_OFF_CTRL, {16'h0, ctc[i], stc[i], 8'h08, 4'(i * 5)});
      n = 0;
      while (sample !== 1'h1) @(posedge mclk_i);
      while (sample === 1'h1) begin
        n++;
        @(posedge mclk_i);
      end
      chk(n, per[i] << stc[i]);
      while (step !== 1'h1) @(posedge mclk_i);
      m = 0;
      do begin
        @(posedge mclk_i);
        m++;
      end while (step !== 1'h1);
      chk(m, per[i]);
      wait_evt;
      xfer(1'h0, `ADCSQ_OFF_RESULT, 32'h0);
      chk(r, res(4'(i * 5)));
      xfer(1'h0, `ADCSQ_OFF_CTRL, 32'h0);
      chk({31'h0, r[8]}, 32'h0);
    end
    xfer(1'h1, `ADCSQ_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1);
    xfer(1'h1, `ADCSQ_OFF_IRQ_STAT, 32'h7);
    n = 0;
    repeat (1200) begin
      @(posedge mclk_i);
      n += (evt === 1'h1);
    end
    chk({31'h0, irq}, 32'h0);
    chk(n, 0);
    $display("clock selection and single conversion done");
  endtask : t_clocks
  task t_hold;
    for (int b = 9; b <= 10; b++) begin
      do_reset;
      xfer(1'h1, `ADCSQ_OFF_CTRL, (32'h1 << b) | 32'h96);
      wait_evt;
      n = 0;
      repeat (1200) begin
        @(posedge mclk_i);
        n += (evt === 1'h1);
      end
      chk(n, 0);
      xfer(1'h0, `ADCSQ_OFF_IRQ_STAT, 32'h0);
      chk({31'h0, r[1]}, 32'h0);
      xfer(1'h0, `ADCSQ_OFF_RESULT, 32'h0);
      chk(r, res(4'h6));
      wait_evt;
      xfer(1'h0, `ADCSQ_OFF_RESULT, 32'h0);
      chk(r, res(4'h6));
    end
    $display("hold modes done");
  endtask : t_hold
  task t_ovr;
    do_reset;
    xfer(1'h1, `ADCSQ_OFF_IRQ_MASK, 32'h2);
    xfer(1'h1, `ADCSQ_OFF_CTRL, 32'h94);
    wait_evt;
    wait_evt;
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1);
    xfer(1'h0, `ADCSQ_OFF_IRQ_STAT, 32'h0);
    chk({30'h0, r[1:0]}, 32'h3);
    xfer(1'h1, `ADCSQ_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    $display("overrun done");
  endtask : t_ovr
  task t_scan;
    logic [3:0] ch [4];
    ch = '{4'h2, 4'h5, 4'h9, 4'h2};
    for (int md = 2; md <= 3; md++) begin
      do_reset;
      xfer(1'h1, `ADCSQ_OFF_SCANMASK, 32'h0224);
      xfer(1'h1, `ADCSQ_OFF_CTRL, 32'h82 | 32'(md << 4));
      xfer(1'h0, `ADCSQ_OFF_CTRL, 32'h0);
      chk({31'h0, r[8]}, 32'h1);
      for (int k = 0; k < md + 1; k++) begin
        wait_evt;
        xfer(1'h0, `ADCSQ_OFF_RESULT, 32'h0);
        chk(r, res(ch[k]));
      end
      xfer(1'h0, `ADCSQ_OFF_DIGIN, 32'h0);
      chk(r, {16'h0, DIG & ~16'h0224});
      repeat (20) @(posedge mclk_i);
      xfer(1'h0, `ADCSQ_OFF_CTRL, 32'h0);
      chk({31'h0, r[8]}, 32'(md == 3));
    end
    $display("scan modes done");
  endtask : t_scan
  task t_inj;
    do_reset;
    xfer(1'h1, `ADCSQ_OFF_IRQ_MASK, 32'h4);
    xfer(1'h1, `ADCSQ_OFF_CTRL, 32'h93);
    xfer(1'h1, `ADCSQ_OFF_INJ, 32'h7);
    xfer(1'h1, `ADCSQ_OFF_CTRL, 32'h813);
    while (irq !== 1'h1) @(posedge mclk_i);
    xfer(1'h0, `ADCSQ_OFF_INJ, 32'h0);
    chk({22'h0, r[9:0]}, {22'h0, 4'h7, 6'h2b});
    xfer(1'h0, `ADCSQ_OFF_CTRL, 32'h0);
    chk({25'h0, r[8], r[5:0]}, 32'h53);
    wait_evt;
    xfer(1'h0, `ADCSQ_OFF_RESULT, 32'h0);
    chk(r, res(4'h3));
    $display("injection done");
  endtask : t_inj
  initial begin
    rst_b_i = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    do_reset;
    t_regs;
    t_clocks;
    t_hold;
    t_ovr;
    t_scan;
    t_inj;
    final_report;
  end
endmodule : tb
